// ===== verif/spc_checker.sv
// port checks of the serial client
`timescale 1ns/1ps
`default_nettype none
module spc_checker
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial pins
  input wire logic        sck_in,
  input wire logic        select_n_in,
  input wire logic        miso_o,
  input wire logic        miso_oe
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_desel;
    select_n_in [*3];
  endsequence
  // a data write may reload the shifter, so it is kept out
  sequence s_quiet;
    (!select_n_in && $stable(sck_in) && !s_axi_awready) [*6];
  endsequence
  AST_OE_DESEL: assert property (s_desel |-> !miso_oe)
    else $error("miso driven while deselected");
  AST_MISO_HOLD: assert property (s_quiet |-> $stable(miso_o))
    else $error("miso moved without a clock edge");
  AST_B_AFTER: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("no read response");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  AST_R_BYTE: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
endmodule
`default_nettype wire

// ===== verif/spc_host_model.sv
// behavioural external serial host for the client pins
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
(
  // serial pins
  output var logic sck,
  output var logic select_n,
  output var logic mosi,
  input  wire logic miso
);
  // ****
  // host
  // ****
  // clock stands low outside frames; select idles high
  initial
  begin
    sck = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
  end
  // offset keeps pin edges off the bench clock edges
  task automatic sel(input logic lvl);
  begin
    #3;
    select_n = lvl;
    if (lvl)
      mosi = ~mosi;
    #400;
  end
  endtask
  // n pulses msb first, miso sampled late in the high phase
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    int i;
  begin
    #3;
    rx = 8'h00;
    for (i = 7; i > 7 - n; i--)
    begin
      mosi = tx[i];
      #200 sck = 1'b1;
      #200 rx[i] = miso;
      sck = 1'b0;
    end
    #400;
  end
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench of the serial client
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"
`define CHK(n, e, g) \
  begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  // ****
  // bench
  // ****
  logic             aclk, aresetn, s_axi_awvalid, s_axi_wvalid;
  logic             s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0]       s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0]      s_axi_wdata;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic        s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic        sck_in, select_n_in, mosi_in, miso_o, miso_oe, miso_w;
  int               mismatches, n_compared, i;
  logic [7:0]       rx, v, cfg;
  spc_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .select_n_in,
    .mosi_in, .miso_o, .miso_oe);
  spc_host_model u_host (.sck(sck_in), .select_n(select_n_in),
    .mosi(mosi_in), .miso(miso_w));
  // no pull on miso: released line floats
  assign miso_w = miso_oe ? miso_o : 1'bz;
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] e);
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // ready held back one edge so a waiting response is seen too
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
  end
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] m, e);
  begin
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata[7:0] & m;
    `CHK($sformatf("reg %h", a), e, v)
  end
  endtask
  task stop_test;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial
  begin
    #1000000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // a write without the low byte lane must leave the register alone
    s_axi_wstrb <= 4'hE;
    wr(`SPC_CONTROL_FIRST, 8'h21, `SPC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    chk(`SPC_CONTROL_FIRST, 8'hFF, `SPC_CTRL_RESET);
    chk(`SPC_INTERRUPT_FLAGS, 8'hFF, `SPC_FLAGS_RESET);
    wr(4'h2, 8'h00, `SPC_RESP_SLVERR);
    wr(`SPC_CONTROL_FIRST, 8'h01, `SPC_RESP_OKAY);
    wr(`SPC_DATA, 8'hA5, `SPC_RESP_OKAY);
    u_host.xfer(8'hFF, 8, rx);
    chk(`SPC_INTERRUPT_FLAGS, 8'h80, 8'h00);
    u_host.sel(1'b0);
    u_host.xfer(8'h3C, 8, rx);
    `CHK("miso byte", 8'hA5, rx)
    chk(`SPC_DATA, 8'hFF, 8'h3C);
    chk(`SPC_INTERRUPT_FLAGS, 8'h80, 8'h80);
    u_host.xfer(8'h96, 3, rx);
    u_host.sel(1'b1);
    u_host.sel(1'b0);
    u_host.xfer(8'h5A, 8, rx);
    chk(`SPC_DATA, 8'hFF, 8'h5A);
    wr(`SPC_INTERRUPT_FLAGS, 8'hFF, `SPC_RESP_OKAY);
    fork
      u_host.xfer(8'hC3, 8, rx);
      #1000 wr(`SPC_DATA, 8'h11, `SPC_RESP_OKAY);
    join
    `CHK("miso byte", 8'h5A, rx)
    chk(`SPC_INTERRUPT_FLAGS, 8'hC0, 8'hC0);
    u_host.xfer(8'h00, 8, rx);
    `CHK("miso byte", 8'hC3, rx)
    wr(`SPC_INTERRUPT_FLAGS, 8'hFF, `SPC_RESP_OKAY);
    wr(`SPC_CONTROL_SECOND, 8'h80, `SPC_RESP_OKAY);
    wr(`SPC_DATA, 8'h43, `SPC_RESP_OKAY);
    chk(`SPC_INTERRUPT_FLAGS, 8'h08, 8'h00);
    wr(`SPC_DATA, 8'h44, `SPC_RESP_OKAY);
    u_host.xfer(8'hE1, 8, rx);
    `CHK("miso byte", 8'h00, rx)
    chk(`SPC_INTERRUPT_FLAGS, 8'h38, 8'h28);
    wr(`SPC_INTERRUPT_FLAGS, 8'hFF, `SPC_RESP_OKAY);
    u_host.xfer(8'hE2, 8, rx);
    `CHK("miso byte", 8'h43, rx)
    chk(`SPC_INTERRUPT_FLAGS, 8'h30, 8'h30);
    u_host.sel(1'b1);
    for (i = 0; i < 3; i++)
    begin
      cfg = 8'h0C & (8'h04 << i);
      wr(`SPC_INTERRUPT_FLAGS, 8'hFF, `SPC_RESP_OKAY);
      wr(`SPC_CONTROL_SECOND, cfg, `SPC_RESP_OKAY);
      wr(`SPC_CONTROL_FIRST, 8'h21, `SPC_RESP_OKAY);
      u_host.sel(1'b0);
      // host bit read back before any new byte is written
      chk(`SPC_CONTROL_FIRST, 8'hFF, cfg ? 8'h21 : 8'h01);
      chk(`SPC_INTERRUPT_FLAGS, 8'h80, cfg ? 8'h00 : 8'h80);
      u_host.sel(1'b1);
    end
    stop_test;
  end
endmodule
bind spc_core spc_checker u_chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sck_in,
  .select_n_in, .miso_o, .miso_oe);
`default_nettype wire

// ===== verilog/spc_core.v
// serial client with multi-host select handling and an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"
module spc_core
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial pins
  input  wire        sck_in,
  input  wire        select_n_in,
  input  wire        mosi_in,
  output wire        miso_o,
  output wire        miso_oe
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg  [1:0] sck_sync_q;
  reg  [1:0] sel_sync_q;
  reg  [1:0] mosi_sync_q;
  reg        sck_prev_q;
  wire       sck_s;
  wire       sel_n_s;
  wire       mosi_s;
  wire       sck_rise;
  wire       sck_fall;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // idle levels, so no false edge or select follows reset
      sck_sync_q  <= 2'h0;
      sel_sync_q  <= 2'h3;
      mosi_sync_q <= 2'h0;
      sck_prev_q  <= 1'b0;
    end
    else
    begin
      // first stage feeds only the second one  see RQ23
      sck_sync_q  <= {sck_sync_q[0], sck_in};
      sel_sync_q  <= {sel_sync_q[0], select_n_in};
      mosi_sync_q <= {mosi_sync_q[0], mosi_in};
      sck_prev_q  <= sck_sync_q[1];
    end
  end

  assign sck_s    = sck_sync_q[1];
  assign sel_n_s  = sel_sync_q[1];
  assign mosi_s   = mosi_sync_q[1];
  // edges only resolve if each phase spans over two clocks  see RQ9
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // ****************************************************************
  // register bus
  // ****************************************************************
  reg  [7:0] ctrl_first_q;
  reg  [7:0] ctrl_second_q;
  reg  [7:0] flags_q;
  reg  [7:0] shreg_q;
  reg  [7:0] rx_data_q;
  reg  [7:0] tx_buf_q;
  wire       wr_take;
  wire       wr_ok;
  wire       wr_ctrl1;
  wire       wr_ctrl2;
  wire       wr_flags;
  wire       wr_data;
  wire [7:0] wbyte;
  reg  [7:0] rd_mux;
  reg        rd_hit;

  // both channels are taken together, so address and data never split
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_ok    = wr_take & s_axi_wstrb[0];
  assign wbyte    = s_axi_wdata[7:0];
  assign wr_ctrl1 = wr_ok & (s_axi_awaddr == `SPC_CONTROL_FIRST);
  assign wr_ctrl2 = wr_ok & (s_axi_awaddr == `SPC_CONTROL_SECOND);
  assign wr_flags = wr_ok & (s_axi_awaddr == `SPC_INTERRUPT_FLAGS);
  assign wr_data  = wr_ok & (s_axi_awaddr == `SPC_DATA);

  always @*
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `SPC_CONTROL_FIRST:   rd_mux = ctrl_first_q;
      `SPC_CONTROL_SECOND:  rd_mux = ctrl_second_q;
      `SPC_INTERRUPT_FLAGS: rd_mux = flags_q;
      `SPC_DATA:            rd_mux = rx_data_q;
      default:
      begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `SPC_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end
    else
    begin
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        case (s_axi_awaddr)
          `SPC_CONTROL_FIRST,
          `SPC_CONTROL_SECOND,
          `SPC_INTERRUPT_FLAGS,
          `SPC_DATA: s_axi_bresp <= `SPC_RESP_OKAY;
          default:   s_axi_bresp <= `SPC_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_mux};
        s_axi_rresp  <= rd_hit ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  wire enabled;
  wire host_mode;
  wire buf_mode;
  wire sel_guard;
  wire host_drop;
  wire client_on;
  wire selected;

  assign enabled   = ctrl_first_q[`SPC_ENABLE_BIT];
  assign host_mode = ctrl_first_q[`SPC_HOST_SELECT_BIT];
  // wait-for-receive set is outside this block and acts as cleared
  assign buf_mode  = ctrl_second_q[`SPC_BUF_ENABLE_BIT]; // see RQ14
  // in host mode only an input select pin with the disable clear is watched
  assign sel_guard = ~ctrl_second_q[`SPC_SEL_DISABLE_BIT]   // see RQ6
                   & ~ctrl_second_q[`SPC_SEL_OUTPUT_BIT];   // see RQ5
  // a low select while hosting means a rival host took the bus
  assign host_drop = enabled & host_mode & sel_guard & ~sel_n_s; // see RQ1
  assign client_on = enabled & ~host_mode;
  assign selected  = client_on & ~sel_n_s;                     // see RQ10

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_first_q  <= `SPC_CTRL_RESET;
      ctrl_second_q <= `SPC_CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl1)
        ctrl_first_q <= wbyte;
      // hardware drop wins over a software write in the same cycle
      if (host_drop)
        ctrl_first_q[`SPC_HOST_SELECT_BIT] <= 1'b0;           // see RQ2
      if (wr_ctrl2)
        ctrl_second_q <= wbyte;
    end
  end

  // ****************************************************************
  // client shift engine
  // ****************************************************************
  reg  [3:0] bit_cnt_q;
  reg        samp_q;
  reg        tx_full_q;
  reg        done_q;
  reg        rxc_pend_q;
  reg        txc_pend_q;
  wire       busy;
  wire       buf_wr;
  wire       coll_wr;
  wire [7:0] shifted;
  wire       byte_done;
  wire       move_buf;

  // a deselect mid-byte keeps the shifted bits; only the count restarts
  assign busy      = selected & (bit_cnt_q != 4'h0);
  assign shifted   = {shreg_q[6:0], samp_q};                   // see RQ21
  assign byte_done = selected & sck_fall & (bit_cnt_q == `SPC_BIT_COUNT);
  assign move_buf  = byte_done & buf_mode & tx_full_q;
  // a full buffer or a busy shifter turns the write away
  assign buf_wr    = wr_data & client_on & buf_mode & ~tx_full_q;  // see RQ17
  assign coll_wr   = wr_data & client_on & ~buf_mode & busy;       // see RQ12
  // the line is driven from the shift register flop, msb first
  assign miso_o    = shreg_q[7];
  assign miso_oe   = selected;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_cnt_q <= 4'h0;
      samp_q    <= 1'b0;
      shreg_q   <= 8'h00;
      rx_data_q <= 8'h00;
      tx_buf_q  <= 8'h00;
      tx_full_q <= 1'b0;
    end
    else
    begin
      if (!selected)
        // select high drops the partial byte at once  see RQ13
        bit_cnt_q <= 4'h0;                                     // see RQ22
      else if (sck_rise)
      begin
        samp_q    <= mosi_s;
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      else if (sck_fall && bit_cnt_q != 4'h0)
      begin
        if (byte_done)
          bit_cnt_q <= 4'h0;
        shreg_q <= shifted;
      end
      if (byte_done)
        rx_data_q <= shifted;
      if (move_buf)
      begin
        // without a queued byte the received one goes out next  see RQ16
        shreg_q   <= tx_buf_q;
        tx_full_q <= 1'b0;
      end
      if (wr_data && client_on)
      begin
        if (buf_mode)
        begin
          // a write lands in the buffer only while it is empty, never the shifter  see RQ15
          if (!tx_full_q)
          begin
            tx_buf_q  <= wbyte;
            tx_full_q <= 1'b1;
          end                                                  // see RQ17
        end
        else if (!busy)
          shreg_q <= wbyte;                                    // see RQ12
      end
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  reg [7:0] flags_d;

  always @*
  begin
    flags_d = flags_q;
    if (wr_flags)
      flags_d = flags_q & ~wbyte;
    // buffer write empties the flag; clear of write loses to move
    if (buf_wr)
      flags_d[`SPC_DRE_FLAG_BIT] = 1'b0;                       // see RQ18
    if (move_buf)
      flags_d[`SPC_DRE_FLAG_BIT] = 1'b1;                       // see RQ18
    if (host_drop)
      flags_d[`SPC_XFER_FLAG_BIT] = 1'b1;                      // see RQ3
    if (byte_done && !buf_mode)
      flags_d[`SPC_XFER_FLAG_BIT] = 1'b1;                      // see RQ11
    if (coll_wr)
      flags_d[`SPC_WCOL_FLAG_BIT] = 1'b1;                      // see RQ12
    if (rxc_pend_q)
      flags_d[`SPC_RXC_FLAG_BIT] = 1'b1;                       // see RQ19
    if (txc_pend_q)
      flags_d[`SPC_TXC_FLAG_BIT] = 1'b1;                       // see RQ20
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= `SPC_FLAGS_RESET;
    else
      flags_q <= flags_d;
  end

  // ****************************************************************
  // buffered flag pipeline
  // ****************************************************************
  // each flag trails the one before by a single clock edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_q     <= 1'b0;
      rxc_pend_q <= 1'b0;
      txc_pend_q <= 1'b0;
    end
    else
    begin
      // empty flag rises at the byte end edge, receive one edge later
      rxc_pend_q <= byte_done & buf_mode;                      // see RQ19
      // a byte end that moved the buffer still has a byte to send
      done_q     <= byte_done & buf_mode & ~tx_full_q;         // see RQ20
      // complete only when shifter and buffer both ran dry
      txc_pend_q <= done_q & ~tx_full_q;                       // see RQ20
    end
  end

endmodule
`default_nettype wire

// ===== verilog/spc_map.vh
// register map, field positions and reset values of the serial client
// ******************************************************************
// Functional notes
// ******************************************************************
// Functional notes
// RQ1: host mode, select enabled as input: low select means another host.
// RQ2: that forced drop clears the host-select bit.
// RQ3: that forced drop sets the transfer flag.
// RQ4: outside circuit holds select high while host mode is wanted.
// RQ5: select configured as output has no effect on host mode.
// RQ6: select-disable set makes the block ignore select fully. The code masks only the host-mode drop; client mode still follows select.
// RQ7: software must set host-select again after a forced drop.
// RQ8: software should check host-select before each new byte.
// RQ9: external serial clock phases each last over two clock cycles.
// RQ10: client normal mode idles while select high; shifts after select low.
// RQ11: client normal mode sets transfer flag after each full byte.
// RQ12: client normal write during transfer is dropped, collision flag set.
// RQ13: select high halts client, drops partial received byte.
// RQ14: buffer-enable turns on buffered mode; wait-for-receive picks variant. The code treats wait-for-receive as cleared.
// RQ15: buffered, wait cleared: writes go to buffer, dummy byte first.
// RQ16: dummy byte is what the shift register holds.
// RQ17: buffered write while buffer full is lost.
// RQ18: buffer-empty clears on buffer write, sets when buffer moves out.
// RQ19: receive-complete sets one cycle after buffer-empty rises.
// RQ20: transfer-complete one cycle later, only if nothing left to send.
// RQ21: eight-bit shift register shifts out and in together.
// RQ22: select high resets the transfer state at once.
// RQ23: serial clock, select and data pass two flip-flops first.
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// byte offsets
`define SPC_CONTROL_FIRST    4'h0
`define SPC_CONTROL_SECOND   4'h4
`define SPC_INTERRUPT_FLAGS  4'h8
`define SPC_DATA             4'hC
// control_first fields
`define SPC_ENABLE_BIT       0
`define SPC_HOST_SELECT_BIT  5
// control_second fields
`define SPC_BUF_ENABLE_BIT   7
`define SPC_BUF_WAIT_BIT     6
`define SPC_SEL_OUTPUT_BIT   3
`define SPC_SEL_DISABLE_BIT  2
// interrupt_flags fields (write one to clear)
`define SPC_XFER_FLAG_BIT    7
`define SPC_WCOL_FLAG_BIT    6
`define SPC_RXC_FLAG_BIT     5
`define SPC_TXC_FLAG_BIT     4
`define SPC_DRE_FLAG_BIT     3
// reset values, bit count and response codes
`define SPC_CTRL_RESET       8'h00
`define SPC_FLAGS_RESET      8'h08
`define SPC_BIT_COUNT        4'h8
`define SPC_RESP_OKAY        2'h0
`define SPC_RESP_SLVERR      2'h2
`endif
